/* File: core/osc_cfg_consts.svh */
`ifndef OSC_CFG_CONSTS_SVH
`define OSC_CFG_CONSTS_SVH

// apb register offsets (byte addresses)
`define CFG_WORD_OFS      12'h000
`define CFG_STATUS_OFS    12'h004
`define CFG_POSTSCALE_OFS 12'h008

// configuration word field positions
`define CFG_CKSM_HI       15
`define CFG_CKSM_LO       14
`define CFG_SRC_HI        9
`define CFG_SRC_LO        8
`define CFG_MODE_HI       3
`define CFG_MODE_LO       0
`define CFG_WORD_MASK     24'h00C30F

// erased word and source codes
`define CFG_ERASED        24'hFFFFFF
`define SRC_PRIMARY       2'h3
`define SRC_LOW_RC        2'h2
`define SRC_FAST_RC       2'h1
`define SRC_SECONDARY     2'h0

// instruction clock ratio and pll factors
`define CYCLE_DIV         4
`define PLL_X4            5'h04
`define PLL_X8            5'h08
`define PLL_X16           5'h10

`endif

/* File: core/osc_cfg_pkg.sv */
package osc_cfg_pkg;
    // primary oscillator operating modes
    typedef enum logic [3:0] {
        ext_clock_mode,
        ext_clock_io_mode,
        ext_rc_mode,
        ext_rc_io_mode,
        mid_crystal_mode,
        high_crystal_mode,
        low_crystal_mode,
        reserved_mode
    } primary_mode_t;
    // selected clock source
    typedef enum logic [1:0] {
        sel_primary,
        sel_secondary,
        sel_fast_rc,
        sel_low_power_rc
    } clk_source_t;
endpackage

/* File: core/clk_divider.sv */
`timescale 1ns/1ns
// divide an input clock enable by a runtime ratio, yields one-cycle ticks
module clk_divider #(
    parameter int W = 8
) (
    input  wire logic         sys_clk,
    input  wire logic         sys_rst,
    input  wire logic         tick_in,   // input rate
    input  wire logic [W-1:0] ratio,     // divide ratio, 0 treated as 1
    output logic              tick_out   // output rate
);
    logic [W-1:0] cnt_q; // counts input ticks

    // counter wraps at ratio-1
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            cnt_q <= '0;
        end else if (tick_in) begin
            if (cnt_q + W'(1) >= ratio) begin
                cnt_q <= '0;
            end else begin
                cnt_q <= cnt_q + W'(1);
            end
        end
    end

    // combinational strobe on wrap
    assign tick_out = tick_in && ((cnt_q + W'(1) >= ratio) || ratio == '0);
endmodule

/* File: core/pll_mult.sv */
`timescale 1ns/1ns
// pll model: emits mult ticks per reference tick, spread evenly is not
// attempted; burst of mult pulses is kept, one per clock
module pll_mult (
    input  wire logic       sys_clk,
    input  wire logic       sys_rst,
    input  wire logic       ref_tick,   // reference edge
    input  wire logic [4:0] mult,       // 4, 8 or 16
    output logic            out_tick    // multiplied rate
);
    logic [4:0] left_q; // pulses still owed

    // load on reference edge, count down otherwise
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            left_q <= '0;
        end else if (ref_tick) begin
            left_q <= mult - 5'h01;
        end else if (left_q != '0) begin
            left_q <= left_q - 5'h01;
        end
    end

    assign out_tick = ref_tick || (left_q != '0);
endmodule

/* File: core/clock_source_config_select.sv */
`timescale 1ns/1ns
`include "osc_cfg_consts.svh"
// How it works
// R1: system clock from exactly one source
// R2: only primary source may use pll
// R3: optional postscaler forms system clock
// R4: instruction clock is system clock over four
// R5: clock-out pin in ext clock/rc modes
// R6: power-on source from nonvolatile config bits
// R7: erased source field picks primary oscillator
// R8: primary mode field picks mode and pll
// R9: bits 15:14 unprogrammed disable switch, monitor
// R10: 1x off, 01 switch, 00 both
// R11: bits 9:8 pick source 11/10/01/00
// R12: unused bit ranges read as zero
// R13: erased word gives ext clock pll16 io
// R14: primary mode decode per table
// R15: pll factors only 4, 8, 16
// R16: crystal modes need crystal across pins
// R17: oscillator input pin never general io
// R18: out pin follows mode field always
// R19: switch field same in every version
// R20: config latched at power-on, then held
module clock_source_config_select (
    input  wire logic        sys_clk,
    input  wire logic        sys_rst,        // power-on reset
    input  wire logic [23:0] cfg_word,       // nonvolatile config word
    input  wire logic        primary_tick,   // primary source edges
    input  wire logic        secondary_tick, // 32 khz source edges
    input  wire logic        fast_rc_tick,   // fast internal rc edges
    input  wire logic        slow_rc_tick,   // low-power rc edges
    input  wire logic        osc_in_pin,     // osc input, clock only
    input  wire logic        osc_out_gpio,   // gpio data for out pin
    input  wire logic        switch_req,     // request new source
    input  wire logic [1:0]  switch_src,     // source code to switch to
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    output logic             sys_tick,       // system clock
    output logic             cycle_tick,     // instruction clock (fcy)
    output logic             osc_out_pin,    // out pin value
    output logic             osc_out_oe,     // out pin driven
    output logic             osc_out_is_io,  // out pin free for io
    output logic             crystal_needed, // crystal across pins
    output logic             switch_enable,  // clock switching allowed
    output logic             fail_safe_monitor // monitor enabled
);
    logic [23:0] cfg_q;       // latched config word, unused bits cleared
    logic        loaded_q;    // config captured since reset
    logic [1:0]  src_q;       // active source code
    logic [7:0]  post_q;      // postscaler ratio
    logic        cyc_q;       // registered instruction clock level
    logic [1:0]  cnt4_q;      // instruction clock phase
    logic [3:0]  mode_bits;   // primary mode field
    logic [1:0]  cksm;        // switch/monitor field
    logic        pll_on;      // primary runs through pll
    logic [4:0]  pll_factor;  // multiplier for pll
    logic        src_tick;    // chosen source tick
    logic        pll_tick;    // after pll
    logic        clkout_mode; // mode drives fcy on out pin
    osc_cfg_pkg::primary_mode_t mode;
    logic [31:0] rdata_d;     // word for the addressed register

    // capture the config once after reset release; reset loads the masked erased word,
    // so the strap value is caught by a clocked step
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            cfg_q    <= `CFG_ERASED & `CFG_WORD_MASK;
            loaded_q <= 1'b0;
        end else if (!loaded_q) begin
            cfg_q    <= cfg_word & `CFG_WORD_MASK; // see R6 see R12 see R20
            loaded_q <= 1'b1;
        end
    end

    // switch/monitor field, same place in all versions
    assign cksm = cfg_q[`CFG_CKSM_HI:`CFG_CKSM_LO]; // see R9 see R19
    assign switch_enable     = loaded_q && !cksm[1]; // see R10
    assign fail_safe_monitor = loaded_q && (cksm == 2'b00); // see R10
    assign mode_bits = cfg_q[`CFG_MODE_HI:`CFG_MODE_LO];

    // active source: power-on field, changed only by allowed switching
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            src_q <= `SRC_PRIMARY; // see R7
        end else if (!loaded_q) begin
            src_q <= cfg_word[`CFG_SRC_HI:`CFG_SRC_LO]; // see R11 see R20
        end else if (switch_req && switch_enable) begin
            src_q <= switch_src;
        end
    end

    // primary mode decode; erased 1111 gives ext clock pll16 io
    always_comb begin
        mode       = osc_cfg_pkg::ext_clock_io_mode;
        pll_factor = `PLL_X4;
        pll_on     = 1'b0;
        case (mode_bits) // see R8 see R14 see R13
            4'hF: begin
                pll_on = 1'b1;
                pll_factor = `PLL_X16;
            end
            4'hE: begin
                pll_on = 1'b1;
                pll_factor = `PLL_X8;
            end
            4'hD: begin
                pll_on = 1'b1;
                pll_factor = `PLL_X4;
            end
            4'hC: mode = osc_cfg_pkg::ext_clock_io_mode;
            4'hB: mode = osc_cfg_pkg::ext_clock_mode;
            4'hA: mode = osc_cfg_pkg::reserved_mode;
            4'h9: mode = osc_cfg_pkg::ext_rc_mode;
            4'h8: mode = osc_cfg_pkg::ext_rc_io_mode;
            4'h7: begin
                mode = osc_cfg_pkg::mid_crystal_mode;
                pll_on = 1'b1;
                pll_factor = `PLL_X16;
            end
            4'h6: begin
                mode = osc_cfg_pkg::mid_crystal_mode;
                pll_on = 1'b1;
                pll_factor = `PLL_X8;
            end
            4'h5: begin
                mode = osc_cfg_pkg::mid_crystal_mode;
                pll_on = 1'b1;
                pll_factor = `PLL_X4;
            end
            4'h4: mode = osc_cfg_pkg::mid_crystal_mode;
            4'h3, 4'h2: mode = osc_cfg_pkg::high_crystal_mode;
            default: mode = osc_cfg_pkg::low_crystal_mode;
        endcase
    end

    // exactly one source feeds the chain
    always_comb begin
        case (src_q) // see R1
            `SRC_PRIMARY:   src_tick = primary_tick;
            `SRC_LOW_RC:    src_tick = slow_rc_tick;
            `SRC_FAST_RC:   src_tick = fast_rc_tick;
            default:        src_tick = secondary_tick;
        endcase
    end

    // pll only on primary path; factor limited to three values
    logic pll_out;
    pll_mult u_pll (
        .sys_clk  (sys_clk),
        .sys_rst  (sys_rst),
        .ref_tick (src_tick),
        .mult     (pll_factor), // see R15
        .out_tick (pll_out)
    );
    assign pll_tick = (pll_on && src_q == `SRC_PRIMARY) ? pll_out
                                                      : src_tick; // see R2

    // postscaler output is the system clock
    clk_divider #(.W(8)) u_post (
        .sys_clk  (sys_clk),
        .sys_rst  (sys_rst),
        .tick_in  (pll_tick),
        .ratio    (post_q), // see R3
        .tick_out (sys_tick)
    );

    // instruction clock is system clock divided by four
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            cnt4_q <= '0;
            cyc_q  <= 1'b0;
        end else if (sys_tick) begin
            cnt4_q <= cnt4_q + 2'h1; // see R4
            if (cnt4_q == 2'(`CYCLE_DIV / 2 - 1) ||
                cnt4_q == 2'(`CYCLE_DIV - 1)) begin
                cyc_q <= ~cyc_q;
            end
        end
    end
    assign cycle_tick = sys_tick && (cnt4_q == 2'(`CYCLE_DIV - 1)); // see R4

    // out pin follows primary mode regardless of source
    assign clkout_mode = !pll_on && (mode == osc_cfg_pkg::ext_clock_mode ||
                                     mode == osc_cfg_pkg::ext_rc_mode);
    assign crystal_needed = (mode == osc_cfg_pkg::mid_crystal_mode ||
                             mode == osc_cfg_pkg::high_crystal_mode ||
                             mode == osc_cfg_pkg::low_crystal_mode);
    // see R16: the crystal mode keeps the pin off both clock-out and io
    assign osc_out_is_io = !clkout_mode && !crystal_needed &&
                           mode != osc_cfg_pkg::reserved_mode; // see R18
    assign osc_out_oe = clkout_mode || osc_out_is_io; // see R5 see R18
    assign osc_out_pin = clkout_mode ? cyc_q : osc_out_gpio; // see R5
    // input pin is only ever a clock input, no io path exists
    logic unused_in;
    assign unused_in = osc_in_pin; // see R17

    // postscaler register, software writable
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            post_q <= 8'h01;
        end else if (psel && penable && pwrite &&
                     paddr == `CFG_POSTSCALE_OFS) begin
            post_q <= pwdata[7:0];
        end
    end

    // apb: zero wait states, unmapped address gives error
    assign pready = 1'b1;
    always_comb begin
        rdata_d = 32'h0;
        pslverr = 1'b0;
        if (paddr == `CFG_WORD_OFS) begin
            rdata_d = {8'h00, cfg_q}; // see R12
        end else if (paddr == `CFG_STATUS_OFS) begin
            rdata_d = {24'h0, crystal_needed, osc_out_is_io,
                       fail_safe_monitor, switch_enable,
                       pll_on, loaded_q, src_q};
        end else if (paddr == `CFG_POSTSCALE_OFS) begin
            rdata_d = {24'h0, post_q};
        end else begin
            pslverr = psel && penable;
        end
    end

    // read data is caught in the setup cycle, so it stands as a flop
    // output through the whole access phase at no extra wait state
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            prdata <= 32'h0;
        end else if (psel && !penable) begin
            prdata <= rdata_d;
        end
    end

    // every check below runs on the one system clock and rests in reset
    default clocking cb_sys @(posedge sys_clk);
    endclocking
    default disable iff (sys_rst);

    // first clock after release, the one that catches the straps
    sequence s_first_load;
        !loaded_q ##1 loaded_q;
    endsequence

    // a switch request that the switch field lets through
    sequence s_switch_taken;
        switch_req && switch_enable;
    endsequence

    // own count of system ticks since the last instruction tick, so the
    // divide check does not merely restate the cnt4_q compare
    logic [2:0] seen_q; // system ticks since last instruction tick
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            seen_q <= '0;
        end else if (cycle_tick) begin
            seen_q <= '0;
        end else if (sys_tick) begin
            seen_q <= seen_q + 3'h1;
        end
    end

    // an erased source field starts the primary oscillator
    a_erased_primary: assert property ( // see R7
        ($rose(loaded_q) && $past(cfg_word[9:8]) == 2'b11)
        |-> src_q == `SRC_PRIMARY)
        else $error("erased source not primary");

    // the power-on source code is taken from the straps as is
    a_por_source: assert property ( // see R11
        s_first_load |-> src_q == $past(cfg_word[`CFG_SRC_HI:`CFG_SRC_LO]))
        else $error("power-on source differs from straps");

    // the caught word is the strap word with unused ranges cleared
    a_por_word: assert property ( // see R6
        s_first_load |-> cfg_q == ($past(cfg_word) & `CFG_WORD_MASK))
        else $error("config word not caught at power-on");

    // a 1x switch field shuts both switching and the monitor off
    a_cksm_off: assert property ( // see R10
        cksm[1] |-> !switch_enable && !fail_safe_monitor)
        else $error("switch field 1x not disabling");

    // the monitor is never on while switching is off
    a_monitor_switch: assert property ( // see R10
        fail_safe_monitor |-> switch_enable)
        else $error("monitor enabled without switching");

    // an allowed request moves the source on the next clock
    a_switch_taken: assert property ( // see R10
        s_switch_taken |=> src_q == $past(switch_src))
        else $error("switch request not applied");

    // the caught word never moves until the next power-on reset
    a_cfg_held: assert property ( // see R20
        loaded_q ##1 loaded_q |-> $stable(cfg_q))
        else $error("config changed after load");

    // without switching the power-on source stays put
    a_src_held: assert property ( // see R20
        loaded_q && !switch_enable |=> $stable(src_q))
        else $error("source changed without switching");

    // unused ranges of the caught word stay zero
    a_unused_zero: assert property ( // see R12
        (cfg_q & ~`CFG_WORD_MASK) == 24'h0)
        else $error("unused config bits set");

    // the erased word means ext clock, pll x16, out pin free for io
    a_erased_word: assert property ( // see R13
        cfg_q == `CFG_WORD_MASK |-> pll_on && pll_factor == `PLL_X16 &&
                                    osc_out_is_io && !crystal_needed)
        else $error("erased word decode wrong");

    // the pll only ever multiplies by four, eight or sixteen
    a_pll_factor: assert property ( // see R15
        pll_on |-> pll_factor == `PLL_X4 || pll_factor == `PLL_X8 ||
                   pll_factor == `PLL_X16)
        else $error("pll factor out of set");

    // sources other than the primary reach the postscaler untouched
    a_pll_primary: assert property ( // see R2
        src_q != `SRC_PRIMARY |-> pll_tick == src_tick)
        else $error("pll used off primary");

    // the postscaler only ever drops ticks, it never makes one
    a_post_subset: assert property ( // see R3
        sys_tick |-> pll_tick)
        else $error("system tick without source tick");

    // crystal modes leave the out pin to the crystal alone
    a_crystal_pin: assert property ( // see R14
        crystal_needed |-> !osc_out_oe && !osc_out_is_io)
        else $error("out pin driven in crystal mode");

    // clock-out modes drive the instruction clock level on the pin
    a_clkout: assert property ( // see R5
        clkout_mode |-> osc_out_oe && osc_out_pin == cyc_q)
        else $error("clock out missing");

    // the instruction tick lands on the phase counter wrap
    a_cycle_div: assert property ( // see R4
        cycle_tick |-> sys_tick && cnt4_q == 2'h3)
        else $error("instruction tick not every fourth");

    // four system ticks make exactly one instruction tick
    a_cycle_count: assert property ( // see R4
        cycle_tick |-> seen_q == 3'h3)
        else $error("instruction tick after wrong tick count");

    // no fourth system tick passes without an instruction tick
    a_no_early_tick: assert property ( // see R4
        sys_tick && !cycle_tick |-> seen_q != 3'h3)
        else $error("instruction tick missed");
endmodule

/* File: testbench/osc_source_model.sv */
`timescale 1ns/1ns
// stands in for what feeds each oscillator source; each source ticks
// at its own period so the bench can tell from the rate which one won
module osc_source_model #(
    parameter int P_PRI = 40,   // primary period in clock cycles
    parameter int P_SEC = 20,   // secondary, scaled far up for speed
    parameter int P_FRC = 16,   // fast internal rc
    parameter int P_LPR = 24    // low-power internal rc
) (
    input  wire logic sys_clk,
    output logic      primary_tick,
    output logic      secondary_tick,
    output logic      fast_rc_tick,
    output logic      slow_rc_tick,
    output logic      osc_in_pin
);
    int cnt_q = 0;  // free-running phase, changes just after each edge

    // one counter drives all sources, so they never drift between runs
    always @(posedge sys_clk) begin
        cnt_q <= cnt_q + 1;
    end

    // pulses are one cycle long, ref ticks far enough apart for pll bursts
    assign primary_tick   = (cnt_q % P_PRI) == 0;
    assign secondary_tick = (cnt_q % P_SEC) == 0;
    assign fast_rc_tick   = (cnt_q % P_FRC) == 0;
    assign slow_rc_tick   = (cnt_q % P_LPR) == 0;
    // crystal across the pins keeps swinging in every mode
    assign osc_in_pin     = (cnt_q % P_PRI) < (P_PRI / 2);
endmodule

/* File: testbench/clock_source_config_select_tb.sv */
`timescale 1ns/1ns
module clock_source_config_select_tb;
    logic        sys_clk, sys_rst;            // clock and power-on reset
    logic [23:0] cfg_word;                    // nonvolatile strap word
    logic        p_t, s_t, f_t, l_t, pin_in;  // source edges from model
    logic        io_o, sw_req, psel, penable, pwrite;
    logic [1:0]  sw_src;                      // switch target code
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, d;
    logic        pready, pslverr, sys_tick, cycle_tick, e;
    logic        out_o, out_oe, out_io, xtal, sw_en, fsm;
    logic [7:0]  x;                           // expected mode traits
    int          n_fail, n_compared, ns, nc, nt;
    int          src_n[3] = '{48, 60, 40};    // secondary, fast, low-power

    osc_source_model osc_source_model_i (.sys_clk(sys_clk),
        .primary_tick(p_t), .secondary_tick(s_t), .fast_rc_tick(f_t),
        .slow_rc_tick(l_t), .osc_in_pin(pin_in));

    clock_source_config_select clock_source_config_select_i (
        .sys_clk(sys_clk), .sys_rst(sys_rst), .cfg_word(cfg_word),
        .primary_tick(p_t), .secondary_tick(s_t), .fast_rc_tick(f_t),
        .slow_rc_tick(l_t), .osc_in_pin(pin_in), .osc_out_gpio(io_o),
        .switch_req(sw_req), .switch_src(sw_src), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .sys_tick(sys_tick), .cycle_tick(cycle_tick),
        .osc_out_pin(out_o), .osc_out_oe(out_oe), .osc_out_is_io(out_io),
        .crystal_needed(xtal), .switch_enable(sw_en),
        .fail_safe_monitor(fsm));

    // 100 mhz clock
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    // verdict, reached from the main sequence or the watchdog
    task automatic complete_run();
        $display("compared %0d, failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // exact compare, four-state so an unknown never matches
    task automatic chk(input logic [31:0] got, exp);
        n_compared++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask

    // rate compare; tolerance covers a burst cut by the window edge
    task automatic near(input int got, exp, tol);
        n_compared++;
        if (got > exp + tol || got < exp - tol) begin
            n_fail++;
            $display("[ERR] %0t rate %0d exp %0d", $time, got, exp);
        end
    endtask

    // one apb transfer; held until pready is seen high at an edge
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] wd);
        int k;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge sys_clk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge sys_clk);
            k++;
        end while (pready !== 1'b1 && k < 50);
        if (k >= 50)
            chk(0, 1);
        d = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge sys_clk);
    endtask

    // power-on reset with a new strap word
    task automatic boot(input logic [23:0] w);
        cfg_word <= w;
        sys_rst <= 1'b1;
        repeat (2) @(posedge sys_clk);
        sys_rst <= 1'b0;
        repeat (3) @(posedge sys_clk);
    endtask

    // counts ticks and out pin changes over a fixed window
    task automatic rate();
        logic last;
        ns = 0;
        nc = 0;
        nt = 0;
        last = out_o;
        repeat (960) begin
            @(posedge sys_clk);
            #1;
            ns += (sys_tick === 1'b1);
            nc += (cycle_tick === 1'b1);
            nt += (out_o !== last);
            last = out_o;
        end
        @(posedge sys_clk);
    endtask

    // traits per mode code: {pll factor, crystal, pin io, clock out}
    function automatic logic [7:0] mode_exp(input logic [3:0] m);
        case (m)
            4'hF: return {5'h10, 3'b010};
            4'hE: return {5'h08, 3'b010};
            4'hD: return {5'h04, 3'b010};
            4'hC, 4'h8: return {5'h01, 3'b010};
            4'hB, 4'h9: return {5'h01, 3'b001};
            4'hA: return 8'h00;
            4'h7: return {5'h10, 3'b100};
            4'h6: return {5'h08, 3'b100};
            4'h5: return {5'h04, 3'b100};
            default: return {5'h01, 3'b100};
        endcase
    endfunction

    // watchdog, well past the expected run of about 23000 cycles
    initial begin
        repeat (60000) @(posedge sys_clk);
        n_fail++;
        complete_run();
    end

    initial begin
        {sys_rst, io_o, sw_req, psel, penable, pwrite} = 6'h20;
        {cfg_word, sw_src, paddr, pwdata} = '0;
        cfg_word = 24'hFFFFFF;
        repeat (10) @(posedge sys_clk);
        sys_rst <= 1'b0;
        repeat (3) @(posedge sys_clk);
        // erased word: unused ranges read zero, pll16 io, no switching
        apb(0, 12'h000, 0);
        chk(d, 32'h0000C30F);
        chk({xtal, out_io, sw_en, fsm}, 4'b0100);
        apb(0, 12'h004, 0);
        chk(d, 32'h0000004F);
        apb(0, 12'h008, 0);
        chk(d, 32'h1);
        apb(1, 12'h000, 32'h0);
        apb(0, 12'h000, 0);
        chk(d, 32'h0000C30F);
        apb(0, 12'h00C, 0);
        chk(e, 1'b1);
        // every primary mode code, source field left erased
        for (int m = 0; m < 16; m++) begin
            io_o <= m[1];
            boot(24'h00C300 | 24'(m));
            x = mode_exp(m[3:0]);
            rate();
            if (m == 10)
                chk(out_oe, 1'b0);
            else begin
                near(ns, 24 * x[7:3], x[7:3] + 1);
                near(nc, ns / 4, 2);
                chk({xtal, out_io}, x[2:1]);
                if (x[0])
                    chk({out_oe, nt > 0}, 2'b11);
                else if (x[1])
                    chk(out_o, io_o);
            end
        end
        // other sources bypass the pll, pin still follows mode field
        for (int s = 0; s < 3; s++) begin
            boot({8'h00, 6'h30, s[1:0], 8'h0F});
            rate();
            near(ns, src_n[s], 2);
            chk(out_io, 1'b1);
        end
        boot(24'h00C10B);
        chk(out_oe, 1'b1);
        // postscaler divides the selected source
        boot(24'h00C30B);
        apb(1, 12'h008, 32'h3);
        rate();
        near(ns, 8, 1);
        // switch field decode, then a switch request to the fast rc
        for (int c = 0; c < 4; c++) begin
            boot({8'h00, c[1:0], 6'h03, 8'h0B});
            chk({sw_en, fsm}, c[1] ? 2'b00 : {1'b1, ~c[0]});
            sw_src <= 2'h1;
            sw_req <= 1'b1;
            @(posedge sys_clk);
            sw_req <= 1'b0;
            repeat (2) @(posedge sys_clk);
            rate();
            near(ns, c[1] ? 24 : 60, 2);
        end
        complete_run();
    end
endmodule
